// ---- flash_spm_pkg.sv ----
// Constants, control-register layout and timing for the self-program sequencer
// Assumes a single core clock and an external flash macro with a done strobe
//
// What this block does
// - Buffer word loads accepted in any order within the page.
// - Erase pattern then store within four cycles erases pointer page.
// - Work on read-while-write area keeps other area readable; else core halts.
// - Load pattern then store within four cycles stores data pair at word.
// - Whole buffer cleared after page write, on re-enable write, and reset.
// - Each buffer word loads once between clears; repeats are ignored.
// - EEPROM write during buffer loading discards all loaded buffer data.
// - Write pattern then store within four cycles writes buffer to page.
// - Interrupt asserted continuously while enabled and enable bit clear.
// - During erase or write, section reads blocked and busy flag set.
// - Busy flag stays set after programming until re-enable bit written.
// - Lock-set pattern then store programs lock bits cleared in low six.
// - Whole flash stays readable while lock bits are programmed.
// - EEPROM write in progress blocks programming and fuse or lock reads.
// - Pointer one, lock-set armed, load within three cycles returns locks.
// - Lock-set and enable self-clear on readback, or window timeouts.
// - Pointer zero readback returns the low fuse byte.
// - Pointer three returns high fuse; pointer two extended fuse, low three.
// - Programmed fuse or lock bits read zero, unprogrammed read one.
// - Address splits into word-in-page low bits and page high bits.
package flash_spm_pkg;
	// Control register bit positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_ERASE = 1;
	localparam int BIT_WRITE = 2;
	localparam int BIT_LOCKSET = 3;
	localparam int BIT_REENABLE = 4;
	localparam int BIT_BUSY = 6;
	localparam int BIT_IRQEN = 7;
	// Command patterns on the low five bits
	localparam logic [4:0] CMD_LOAD = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_REEN = 5'h11;
	// Cycle windows
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW = 3'h3;
	// Readback pointer values
	localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	localparam logic [7:0] LOCK_RESET = 8'hFF;
	localparam logic [5:0] LOCK_FIELD = 6'h3F;
	localparam logic [7:0] EXT_MASK = 8'h07;
	localparam int DATA_W = 16;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_BUSY = 4'b0100,
		ST_LOCKW = 4'b1000
	} seq_state_t;
endpackage

// ---- page_buffer.sv ----
// Temporary page buffer with once-only word loads
// Assumes loads and clears come from the sequencer in the same clock domain
`timescale 1ns/1ns
module page_buffer #(
	parameter int WORDS = 64,
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic clearAll,
	input wire logic loadEn,
	input wire logic [AW-1:0] loadAddr,
	input wire logic [flash_spm_pkg::DATA_W-1:0] loadData,
	// Read port for the flash macro
	input wire logic [AW-1:0] readAddr,
	output logic [flash_spm_pkg::DATA_W-1:0] readData
);
	import flash_spm_pkg::*;

	typedef struct packed {
		logic [WORDS-1:0] used;
		logic [WORDS-1:0][DATA_W-1:0] mem;
	} buf_t;

	buf_t cur_ff;
	buf_t nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (clearAll) begin
			nxt_cur.used = '0;
			nxt_cur.mem = '1;
		end else if (loadEn && !cur_ff.used[loadAddr]) begin
			nxt_cur.used[loadAddr] = 1'b1;
			nxt_cur.mem[loadAddr] = loadData;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_ff.used <= '0;
			cur_ff.mem <= '1;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign readData = cur_ff.mem[readAddr];
endmodule // page_buffer

// ---- flash_self_program_sequencer.sv ----
// Self-program sequencer: control register, timed store/load windows,
// section busy and halt, lock and fuse readback
// Assumes the core signals store and program-load as one-cycle strobes and
// the flash macro acknowledges an operation with a one-cycle done pulse
`timescale 1ns/1ns
module flash_self_program_sequencer #(
	parameter int WORD_BITS = 6,
	parameter int PAGE_BITS = 9
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register port
	input wire logic [0:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Core instruction strobes and operands
	input wire logic storeStrobe,
	input wire logic loadStrobe,
	input wire logic [15:0] zPointer,
	input wire logic [7:0] dataLowRegister,
	input wire logic [7:0] dataHighRegister,
	output logic [7:0] readbackData,
	output logic readbackValid,
	// Program the pointer address targets the no-read-while-write area
	input wire logic ptrInNrwwArea,
	// EEPROM interlock
	input wire logic eepromWriteBusyFlag,
	input wire logic eepromWriteStart,
	// Fuses and locks as stored (one means unprogrammed)
	input wire logic [7:0] fuseLowByte,
	input wire logic [7:0] fuseHighByte,
	input wire logic [7:0] fuseExtendedByte,
	// Flash macro
	output logic flashErase,
	output logic flashWrite,
	output logic [PAGE_BITS-1:0] flashPage,
	input wire logic flashDone,
	input wire logic [WORD_BITS-1:0] bufReadAddr,
	output logic [flash_spm_pkg::DATA_W-1:0] bufReadData,
	// Core side status
	output logic rwwReadBlock,
	output logic coreHalt,
	output logic spmIrq,
	output logic [7:0] lockBits
);
	import flash_spm_pkg::*;

	// ------------------------------------------------
	// Register map
	// ------------------------------------------------
	localparam logic [0:0] ADDR_CTRL = 1'h0;
	localparam logic [0:0] ADDR_DATA = 1'h1;

	// ------------------------------------------------
	// State record
	// ------------------------------------------------
	typedef struct packed {
		seq_state_t state;
		logic [4:0] cmd;
		logic irqEn;
		logic busy;
		logic [2:0] cnt;
		logic opWrite;
		logic opNrww;
		logic [PAGE_BITS-1:0] page;
		logic [7:0] locks;
		logic [7:0] rdData;
		logic [7:0] rbData;
		logic rbValid;
		logic erase;
		logic write;
		logic block;
		logic halt;
		logic irq;
	} seq_t;

	seq_t cur_ff;
	seq_t nxt_cur;
	logic bufClear;
	logic bufLoad;

	// ------------------------------------------------
	// Pointer decoding and register view
	// ------------------------------------------------
	// Word field of the pointer; pointer bit 0 is the byte select
	function automatic logic [WORD_BITS-1:0] wordOf(input logic [15:0] z);
		wordOf = z[WORD_BITS:1];
	endfunction

	function automatic logic [PAGE_BITS-1:0] pageOf(input logic [15:0] z);
		pageOf = z[WORD_BITS+PAGE_BITS:WORD_BITS+1];
	endfunction

	function automatic logic [7:0] ctrlView(input seq_t s);
		logic [7:0] v;
		v = 8'h00;
		v[BIT_ENABLE+4:BIT_ENABLE] = s.cmd;
		v[BIT_BUSY] = s.busy;
		v[BIT_IRQEN] = s.irqEn;
		ctrlView = v;
	endfunction

	// ------------------------------------------------
	// Temporary page buffer
	// ------------------------------------------------
	page_buffer #(
		.WORDS(1 << WORD_BITS),
		.AW(WORD_BITS)
	) u_buf (
		.core_clk(core_clk),
		.rst(rst),
		.clearAll(bufClear),
		.loadEn(bufLoad),
		.loadAddr(wordOf(zPointer)),
		.loadData({dataHighRegister, dataLowRegister}),
		.readAddr(bufReadAddr),
		.readData(bufReadData)
	);

	// ------------------------------------------------
	// Next state
	// ------------------------------------------------
	always_comb begin
		nxt_cur = cur_ff;
		bufClear = 1'b0;
		bufLoad = 1'b0;
		nxt_cur.rbValid = 1'b0;
		nxt_cur.erase = 1'b0;
		nxt_cur.write = 1'b0;
		// EEPROM write discards loaded words
		if (eepromWriteStart) begin
			bufClear = 1'b1;
		end
		// Register writes
		if (regWrite && regAddr == ADDR_CTRL) begin
			nxt_cur.irqEn = regWrData[BIT_IRQEN];
			if (cur_ff.state == ST_IDLE && !eepromWriteBusyFlag &&
			    regWrData[BIT_ENABLE]) begin
				nxt_cur.cmd = regWrData[BIT_ENABLE+4:BIT_ENABLE];
				nxt_cur.cnt = 3'h0;
				nxt_cur.state = ST_ARMED;
			end
		end
		case (cur_ff.state)
			ST_IDLE: begin
			end
			ST_ARMED: begin
				nxt_cur.cnt = cur_ff.cnt + 3'h1;
				if (storeStrobe) begin
					nxt_cur.cnt = 3'h0;
					case (cur_ff.cmd)
						CMD_LOAD: begin
							bufLoad = !eepromWriteStart;
							nxt_cur.cmd = 5'h00;
							nxt_cur.state = ST_IDLE;
						end
						CMD_ERASE, CMD_WRITE: begin
							nxt_cur.page = pageOf(zPointer);
							nxt_cur.opWrite = cur_ff.cmd == CMD_WRITE;
							nxt_cur.opNrww = ptrInNrwwArea;
							nxt_cur.erase = cur_ff.cmd == CMD_ERASE;
							nxt_cur.write = cur_ff.cmd == CMD_WRITE;
							nxt_cur.busy = 1'b1;
							nxt_cur.block = 1'b1;
							nxt_cur.halt = ptrInNrwwArea;
							nxt_cur.state = ST_BUSY;
						end
						CMD_LOCK: begin
							nxt_cur.locks[5:0] = cur_ff.locks[5:0] &
								dataLowRegister[5:0];
							nxt_cur.state = ST_LOCKW;
						end
						CMD_REEN: begin
							nxt_cur.busy = 1'b0;
							nxt_cur.block = 1'b0;
							bufClear = 1'b1;
							nxt_cur.cmd = 5'h00;
							nxt_cur.state = ST_IDLE;
						end
						default: begin
							nxt_cur.cmd = 5'h00;
							nxt_cur.state = ST_IDLE;
						end
					endcase
				end else if (loadStrobe && cur_ff.cmd == CMD_LOCK &&
				             cur_ff.cnt < LOAD_WINDOW) begin
					case (zPointer)
						PTR_LOCK: nxt_cur.rbData = cur_ff.locks;
						PTR_FUSE_LOW: nxt_cur.rbData = fuseLowByte;
						PTR_FUSE_HIGH: nxt_cur.rbData = fuseHighByte;
						PTR_FUSE_EXT: nxt_cur.rbData = fuseExtendedByte &
							EXT_MASK;
						default: nxt_cur.rbData = LOCK_RESET;
					endcase
					nxt_cur.rbValid = 1'b1;
					nxt_cur.cmd = 5'h00;
					nxt_cur.state = ST_IDLE;
				end else if (cur_ff.cnt + 3'h1 >= STORE_WINDOW) begin
					nxt_cur.cmd = 5'h00;
					nxt_cur.cnt = 3'h0;
					nxt_cur.state = ST_IDLE;
				end
			end
			ST_BUSY: begin
				if (flashDone) begin
					if (cur_ff.opWrite) begin
						bufClear = 1'b1;
					end
					nxt_cur.halt = 1'b0;
					nxt_cur.cmd = 5'h00;
					nxt_cur.state = ST_IDLE;
				end
			end
			ST_LOCKW: begin
				if (flashDone) begin
					nxt_cur.cmd = 5'h00;
					nxt_cur.state = ST_IDLE;
				end
			end
			default: begin
				nxt_cur.state = ST_IDLE;
				nxt_cur.cmd = 5'h00;
			end
		endcase
		// Fuse and lock readback shows nothing while EEPROM busy
		if (eepromWriteBusyFlag) begin
			nxt_cur.rbValid = 1'b0;
		end
		if (regRead) begin
			nxt_cur.rdData = (regAddr == ADDR_DATA) ? cur_ff.locks :
				ctrlView(cur_ff);
		end else begin
			nxt_cur.rdData = 8'h00;
		end
		nxt_cur.irq = nxt_cur.irqEn && !nxt_cur.cmd[0];
	end

	// ------------------------------------------------
	// State register
	// ------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_ff.state <= ST_IDLE;
			cur_ff.cmd <= 5'h00;
			cur_ff.irqEn <= 1'b0;
			cur_ff.busy <= 1'b0;
			cur_ff.cnt <= 3'h0;
			cur_ff.opWrite <= 1'b0;
			cur_ff.opNrww <= 1'b0;
			cur_ff.page <= '0;
			cur_ff.locks <= LOCK_RESET;
			cur_ff.rdData <= 8'h00;
			cur_ff.rbData <= 8'h00;
			cur_ff.rbValid <= 1'b0;
			cur_ff.erase <= 1'b0;
			cur_ff.write <= 1'b0;
			cur_ff.block <= 1'b0;
			cur_ff.halt <= 1'b0;
			cur_ff.irq <= 1'b0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------
	assign regRdData = cur_ff.rdData;
	assign readbackData = cur_ff.rbData;
	assign readbackValid = cur_ff.rbValid;
	assign flashErase = cur_ff.erase;
	assign flashWrite = cur_ff.write;
	assign flashPage = cur_ff.page;
	assign rwwReadBlock = cur_ff.block;
	assign coreHalt = cur_ff.halt;
	assign spmIrq = cur_ff.irq;
	assign lockBits = cur_ff.locks;
endmodule // flash_self_program_sequencer

// ---- flash_macro_model.sv ----
// Flash macro stand-in: answers each started operation with a done pulse
// Assumes start is a one-cycle pulse on the core clock
`timescale 1ns/1ns
module flash_macro_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Operation start and pace
	input wire logic start,
	input wire logic slow,
	// Completion
	output logic flashDone
);
	logic [7:0] cnt_ff;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 8'h00;
			flashDone <= 1'b0;
		end else begin
			flashDone <= (cnt_ff == 8'h01);
			if (start) begin
				cnt_ff <= slow ? 8'h28 : 8'h03;
			end else if (cnt_ff != 8'h00) begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule // flash_macro_model

// ---- flash_self_program_sequencer_checker.sv ----
// Port-level assertions for the self-program sequencer
// Assumes one core clock domain with rst as its asynchronous reset
`timescale 1ns/1ns
module flash_self_program_sequencer_checker (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Watched ports
	input wire logic [0:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic storeStrobe,
	input wire logic loadStrobe,
	input wire logic readbackValid,
	input wire logic ptrInNrwwArea,
	input wire logic eepromWriteBusyFlag,
	input wire logic flashErase,
	input wire logic flashWrite,
	input wire logic flashDone,
	input wire logic rwwReadBlock,
	input wire logic coreHalt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_erase_go;
		regWrite && !regAddr[0] && regWrData[4:0] == 5'h03
			&& !eepromWriteBusyFlag && !rwwReadBlock && !coreHalt
			##1 storeStrobe;
	endsequence
	chk_erase_start: assert property (s_erase_go |=> flashErase)
		else $error("erase not launched");
	chk_erase_pulse: assert property (flashErase |=> !flashErase)
		else $error("erase strobe too long");
	chk_busy_block: assert property (flashErase || flashWrite |-> rwwReadBlock)
		else $error("section not blocked");
	chk_halt_rww: assert property (coreHalt |-> rwwReadBlock)
		else $error("halt without block");
	chk_halt_cause: assert property ($rose(coreHalt) |->
		$past(storeStrobe) && $past(ptrInNrwwArea))
		else $error("halt without no_read_while_write_area store");
	chk_halt_end: assert property (coreHalt && flashDone |=> !coreHalt)
		else $error("halt outlived done");
	chk_unblock_cause: assert property ($fell(rwwReadBlock) |->
		$past(storeStrobe) || $past(storeStrobe, 2))
		else $error("block dropped without store");
	chk_eeprom_guard: assert property (eepromWriteBusyFlag &&
		$past(eepromWriteBusyFlag) |-> !flashErase && !flashWrite)
		else $error("flash op during eeprom write");
	chk_rb_cause: assert property (readbackValid |-> $past(loadStrobe))
		else $error("readback without load");
endmodule // flash_self_program_sequencer_checker
bind flash_self_program_sequencer flash_self_program_sequencer_checker i_chk (.*);

// ---- test_flash_self_program_sequencer.sv ----
// Self-checking bench for the self-program sequencer
// Assumes the flash macro model and the bound checker are compiled with it
`timescale 1ns/1ns
module test_flash_self_program_sequencer;
	import flash_spm_pkg::*;
	logic core_clk = 0, rst = 1, regWrite = 0, regRead = 0, storeStrobe = 0;
	logic loadStrobe = 0, ptrInNrwwArea = 0, eepromWriteBusyFlag = 0;
	logic eepromWriteStart = 0, kick = 0, slow = 1, rdPend = 0;
	logic flashDone, readbackValid, flashErase, flashWrite;
	logic rwwReadBlock, coreHalt, spmIrq;
	logic [0:0] regAddr = 0;
	logic [7:0] regWrData = 0, dataLowRegister = 0, dataHighRegister = 0;
	logic [7:0] fuseLowByte = 0, fuseHighByte = 0, fuseExtendedByte = 0;
	logic [7:0] regRdData, readbackData, lockBits;
	logic [15:0] zPointer = 0, bufReadData, d;
	logic [15:0] m [2];
	logic [8:0] flashPage;
	logic [5:0] bufReadAddr = 0, w;
	logic [7:0] qr[$], qb[$];
	int miscompares = 0, tests_run = 0, cyc = 0;

	always #10 core_clk = ~core_clk;
	flash_self_program_sequencer i_dut (.*);
	flash_macro_model i_mem (.core_clk, .rst,
		.start(flashErase | flashWrite | kick), .slow, .flashDone);

	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Control write, then store (s[0]) or load (s[1]) in the next cycle
	task automatic cmd(input logic [7:0] v, input logic [15:0] z,
			input logic [1:0] s);
		zPointer <= z;
		regAddr <= 1'b0;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
		storeStrobe <= s[0];
		loadStrobe <= s[1];
		@(posedge core_clk);
		storeStrobe <= 1'b0;
		loadStrobe <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [0:0] a, input logic [7:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		qr.push_back(e);
		@(posedge core_clk);
		regRead <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic lpm(input logic [15:0] z, input logic [7:0] e);
		qb.push_back(e);
		cmd(8'h09, z, 2'b10);
	endtask
	task automatic bufchk(input logic [5:0] a, input logic [15:0] e);
		bufReadAddr <= a;
		@(posedge core_clk);
		chk(e, bufReadData);
	endtask
	task automatic done();
		do @(posedge core_clk); while (!flashDone);
		repeat (2) @(posedge core_clk);
	endtask

	// ------------------------------------------------
	// Result watcher and hang guard
	// ------------------------------------------------
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 2000) begin
			miscompares++;
			end_sim();
		end
		if (rdPend) chk({8'h00, qr.pop_front()}, {8'h00, regRdData});
		if (readbackValid) chk({8'h00, qb.pop_front()}, {8'h00, readbackData});
		rdPend <= regRead;
	end

	initial begin
		void'($urandom(32'h3a74e184));
		fuseLowByte <= 8'($urandom);
		fuseHighByte <= 8'($urandom);
		fuseExtendedByte <= 8'($urandom);
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk(16'hFFFF, bufReadData);
		chk(16'h00FF, {8'h00, lockBits});
		rd(1'b0, 8'h00);
		for (int i = 0; i < 3; i++) begin
			w = (i == 1) ? 6'h02 : 6'h05;
			d = 16'($urandom);
			dataHighRegister <= d[15:8];
			dataLowRegister <= d[7:0];
			if (i < 2) m[i] = d;
			cmd(8'h01, {9'h14B, w, 1'b0}, 2'b01);
		end
		bufchk(6'h05, m[0]);
		bufchk(6'h02, m[1]);
		cmd(8'h80, 16'h0000, 2'b00);
		chk(16'h0001, {15'h0, spmIrq});
		cmd(8'h83, 16'hA5C3, 2'b01);
		chk(16'h014B, {7'h0, flashPage});
		chk(16'h0000, {14'h0, coreHalt, spmIrq});
		rd(1'b0, 8'hC3);
		done();
		rd(1'b0, 8'hC0);
		chk(16'h0001, {15'h0, spmIrq});
		cmd(8'h91, 16'h0000, 2'b01);
		rd(1'b0, 8'h80);
		bufchk(6'h05, 16'hFFFF);
		slow <= 1'b0;
		ptrInNrwwArea <= 1'b1;
		cmd(8'h01, {9'h14B, 6'h05, 1'b0}, 2'b01);
		cmd(8'h05, 16'hA580, 2'b01);
		chk(16'h0001, {15'h0, coreHalt});
		done();
		chk(16'h0000, {15'h0, coreHalt});
		bufchk(6'h05, 16'hFFFF);
		ptrInNrwwArea <= 1'b0;
		cmd(8'h11, 16'h0000, 2'b01);
		lpm(PTR_FUSE_LOW, fuseLowByte);
		lpm(PTR_LOCK, LOCK_RESET);
		lpm(PTR_FUSE_EXT, fuseExtendedByte & EXT_MASK);
		lpm(PTR_FUSE_HIGH, fuseHighByte);
		cmd(8'h09, PTR_LOCK, 2'b00);
		repeat (2) @(posedge core_clk);
		rd(1'b0, 8'h00);
		dataLowRegister <= 8'hF5;
		cmd(8'h09, PTR_LOCK, 2'b01);
		chk(16'h00F5, {8'h00, lockBits});
		chk(16'h0000, {15'h0, rwwReadBlock});
		rd(1'b1, 8'hF5);
		kick <= 1'b1;
		@(posedge core_clk);
		kick <= 1'b0;
		done();
		lpm(PTR_LOCK, 8'hF5);
		cmd(8'h01, {9'h14B, 6'h02, 1'b0}, 2'b01);
		eepromWriteStart <= 1'b1;
		@(posedge core_clk);
		eepromWriteStart <= 1'b0;
		bufchk(6'h02, 16'hFFFF);
		eepromWriteBusyFlag <= 1'b1;
		cmd(8'h03, 16'hA580, 2'b01);
		rd(1'b0, 8'h00);
		eepromWriteBusyFlag <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(16'h0000, 16'(qb.size() + qr.size()));
		end_sim();
	end
endmodule // test_flash_self_program_sequencer
